// *** tops_pkg.sv ***
// Purpose: Shared constants and types for the triggered one-shot pulse timer
// Assumes: 16-bit counter and compare registers, single ref_clk domain
// Notes:   Codes of control fields and reset values live here
`default_nettype none
package tops_pkg;
   localparam int          TOPS_CNT_W       = 16;            // Counter and compare width
   localparam logic [15:0] TOPS_CNT_RST     = 16'h0000;      // Counter value after reset
   localparam logic [15:0] TOPS_CNT_MAX     = 16'hffff;      // Overflow point
   localparam logic [15:0] TOPS_CMP_RST     = 16'hffff;      // Compare registers after reset
   localparam logic [5:0]  TOPS_DIV_RST     = 6'h00;         // Prescaler after reset
   // Count source selection codes
   typedef enum logic [2:0]
   {
      TOPS_SRC_DIV1  = 3'b000,
      TOPS_SRC_DIV2  = 3'b001,
      TOPS_SRC_DIV4  = 3'b010,
      TOPS_SRC_DIV8  = 3'b011,
      TOPS_SRC_DIV32 = 3'b100,
      TOPS_SRC_OSC   = 3'b101,
      TOPS_SRC_EXT   = 3'b110
   } tops_src_e;
   // Trigger edge field codes
   localparam logic [1:0]  TOPS_TRG_OFF     = 2'b00;
   localparam logic [1:0]  TOPS_TRG_RISE    = 2'b01;
   localparam logic [1:0]  TOPS_TRG_FALL    = 2'b10;
   localparam logic [1:0]  TOPS_TRG_BOTH    = 2'b11;
   // Run state of the counter
   typedef enum logic [1:0]
   {
      TOPS_ST_IDLE = 2'b00,
      TOPS_ST_ARM  = 2'b01,
      TOPS_ST_RUN  = 2'b10
   } tops_state_e;
endpackage : tops_pkg
`default_nettype wire

// *** tops_if.sv ***
// Purpose: Carrier between the pin conditioner and the pulse core
// Assumes: Single clock domain, all signals synchronous to ref_clk
// Notes:   Carries one-cycle edge pulses of the synchronised pins
`default_nettype none
interface tops_if;
   logic trg_rise;    // Rising edge of trigger pin, one cycle
   logic trg_fall;    // Falling edge of trigger pin, one cycle
   logic ext_rise;    // Rising edge of external count clock, one cycle
   logic osc_rise;    // Rising edge of fast oscillator, one cycle
   modport cond (output trg_rise, output trg_fall, output ext_rise, output osc_rise);
   modport core (input trg_rise, input trg_fall, input ext_rise, input osc_rise);
endinterface : tops_if
`default_nettype wire

// *** tops_pin_sync.sv ***
// Purpose: Two-stage synchronisers and edge detectors for the asynchronous pins
// Assumes: Pins slower than half of ref_clk
// Notes:   First stage is read only by the second stage
`default_nettype none
module tops_pin_sync
   import tops_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic trigger_input_pin,
   input  wire logic external_count_clock_pin,
   input  wire logic internal_osc_fast_clock,
   tops_if.cond      pins
);
   logic [2:0] s1_reg;    // First stage, metastability catcher
   logic [2:0] s2_reg;    // Second stage, safe level
   logic [2:0] s3_reg;    // Delayed copy for edge detection

   // Edges come from the second and third stages only
   assign pins.trg_rise = s2_reg[0] & ~s3_reg[0];
   assign pins.trg_fall = ~s2_reg[0] & s3_reg[0];
   assign pins.ext_rise = s2_reg[1] & ~s3_reg[1];
   assign pins.osc_rise = s2_reg[2] & ~s3_reg[2];

   // Synchroniser chain
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= 3'h0;
         s2_reg <= 3'h0;
         s3_reg <= 3'h0;
      end
      else
      begin
         s1_reg <= {internal_osc_fast_clock, external_count_clock_pin, trigger_input_pin};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
endmodule : tops_pin_sync
`default_nettype wire

// *** tops_timer.sv ***
// Purpose: Triggered one-shot pulse mode of a general-purpose timer
// Assumes: Control bits are plain ports, held stable while counting
// Notes:   One pulse output, compare and overflow events as pulses
// Function
// - One pulse waveform on one dedicated pin
// - Wait, then active level, then inactive
// - Mode excludes every other timer mode
// - Selectable divided, oscillator or external source
// - Period is period register plus one
// - Pulse width is end minus wait
// - Wait is wait register plus one
// - Start bit alone starts when untriggered
// - Trigger mode needs start bit and edge
// - Clearing start stops, initial level, keeps count
// - One-shot stops on period match, initial level
// - One-shot stop clears counter if enabled
// - Event on match with any compare
// - Event on counter overflow
// - First pin is port or trigger
// - Trigger edge rising, falling or both
// - Fourth register buffers next change point
`default_nettype none
module tops_timer
   import tops_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        count_start_bit,
   input  wire logic        trigger_edge_sel_hi,
   input  wire logic        trigger_edge_sel_lo,
   input  wire logic        one_shot_select_bit,
   input  wire logic        output_initial_level_bit,
   input  wire logic        clear_on_period_match_bit,
   input  wire logic        buffer_enable_fourth,
   input  wire logic        first_pin_trigger_sel,
   input  wire logic [2:0]  count_source_sel,
   input  wire logic [15:0] period_compare_reg,
   input  wire logic [15:0] pulse_end_compare_reg,
   input  wire logic [15:0] wait_compare_reg,
   input  wire logic [15:0] buffer_compare_reg,
   input  wire logic        trigger_input_pin,
   input  wire logic        external_count_clock_pin,
   input  wire logic        internal_osc_fast_clock,
   output logic             pwm_output_pin,
   output logic             pwm_output_pin_oe,
   output logic [15:0]      timer_counter_value,
   output logic [3:0]       compare_match_event,
   output logic             overflow_event,
   output logic             counting
);
   tops_if                  pins ();                 // Conditioned pin edges
   tops_state_e             state_reg, state_next;   // Run state
   logic [15:0]             cnt_reg;                 // Counter
   logic [15:0]             cnt_next;                // Next counter value
   logic [5:0]              div_reg;                 // Free prescaler
   logic                    out_reg;                 // Output level
   logic [15:0]             end_point;               // Effective end compare
   logic                    tick;                    // Count-source enable
   logic                    trg_edge;                // Valid trigger edge
   logic                    trg_used;                // Trigger gating active
   logic                    m_per, m_end, m_wait, m_buf;   // Compare hits
   logic                    ovf;                     // Overflow this tick
   logic                    one_stop;                // One-shot end
   logic                    run_tick;                // Counting tick
   logic                    done_reg;                // Untriggered shot spent until start drops

   // Pin conditioning, trigger pin shares the first timer pin
   tops_pin_sync u_sync
   (
      .ref_clk                  (ref_clk),
      .rst_n                    (rst_n),
      .trigger_input_pin        (trigger_input_pin),
      .external_count_clock_pin (external_count_clock_pin),
      .internal_osc_fast_clock  (internal_osc_fast_clock),
      .pins                     (pins)
   );

   // Count source, always on for DIV1, else one-cycle enable pulses from the prescaler or the synchronised pin edges
   assign tick = (count_source_sel == TOPS_SRC_DIV1)  ? 1'b1 :
                 (count_source_sel == TOPS_SRC_DIV2)  ? (div_reg[0] == 1'b1) :
                 (count_source_sel == TOPS_SRC_DIV4)  ? (div_reg[1:0] == 2'h3) :
                 (count_source_sel == TOPS_SRC_DIV8)  ? (div_reg[2:0] == 3'h7) :
                 (count_source_sel == TOPS_SRC_DIV32) ? (div_reg[4:0] == 5'h1f) :
                 (count_source_sel == TOPS_SRC_OSC)   ? pins.osc_rise :
                 (count_source_sel == TOPS_SRC_EXT)   ? pins.ext_rise : 1'b0;

   // Trigger edge decode; pin only used as trigger when selected
   assign trg_edge = first_pin_trigger_sel &&
                     ((({trigger_edge_sel_hi, trigger_edge_sel_lo} == TOPS_TRG_RISE) &&
                       pins.trg_rise) ||
                      (({trigger_edge_sel_hi, trigger_edge_sel_lo} == TOPS_TRG_FALL) &&
                       pins.trg_fall) ||
                      (({trigger_edge_sel_hi, trigger_edge_sel_lo} == TOPS_TRG_BOTH) &&
                       (pins.trg_rise || pins.trg_fall)));
   // Untriggered or continuous setting starts on the start bit alone
   assign trg_used = ({trigger_edge_sel_hi, trigger_edge_sel_lo} != TOPS_TRG_OFF) &&
                     one_shot_select_bit;

   // Buffered change point replaces the end register when enabled
   assign end_point = buffer_enable_fourth ? buffer_compare_reg : pulse_end_compare_reg;

   // Compare decode, against the count seen this tick
   assign run_tick = (state_reg == TOPS_ST_RUN) && tick && count_start_bit;
   assign m_per    = run_tick && (cnt_reg == period_compare_reg);
   assign m_end    = run_tick && (cnt_reg == pulse_end_compare_reg);
   assign m_wait   = run_tick && (cnt_reg == wait_compare_reg);
   assign m_buf    = run_tick && (cnt_reg == buffer_compare_reg);
   assign ovf      = run_tick && (cnt_reg == TOPS_CNT_MAX);
   assign one_stop = m_per && one_shot_select_bit;

   // Counter: continuous period match wraps to zero so the period is m plus one
   assign cnt_next = one_stop ? (clear_on_period_match_bit ? TOPS_CNT_RST : cnt_reg) :
                     m_per    ? TOPS_CNT_RST :
                                cnt_reg + 16'h0001;

   // Run state: idle, armed waiting for trigger, running
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         TOPS_ST_IDLE:
         begin
            // A spent one-shot must not relaunch while start is still held
            if (count_start_bit && !done_reg)
               state_next = trg_used ? TOPS_ST_ARM : TOPS_ST_RUN;
         end
         TOPS_ST_ARM:
         begin
            if (!count_start_bit)
               state_next = TOPS_ST_IDLE;
            else if (trg_edge)
               state_next = TOPS_ST_RUN;
         end
         TOPS_ST_RUN:
         begin
            if (!count_start_bit)
               state_next = TOPS_ST_IDLE;
            else if (one_stop)
               state_next = trg_used ? TOPS_ST_ARM : TOPS_ST_IDLE;
         end
         default:
            state_next = TOPS_ST_IDLE;
      endcase
   end

   // Prescaler free-runs so divided sources stay phase steady
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= TOPS_DIV_RST;
      else
         div_reg <= div_reg + 6'h01;
   end

   // State and counter; stop keeps the count
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= TOPS_ST_IDLE;
         cnt_reg   <= TOPS_CNT_RST;
         done_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (run_tick)
            cnt_reg <= cnt_next;
         // Spent flag: set by an untriggered shot, cleared by writing start low
         if (!count_start_bit)
            done_reg <= 1'b0;
         else if (one_stop && !trg_used)
            done_reg <= 1'b1;
      end
   end

   // Output: wait match goes active, end match inactive; the active level
   // is the inverse of the initial level. Period match takes priority so, in continuous
   // mode, a compare equal to the period leaves the level alone.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         out_reg <= 1'b0;
      else if (state_reg != TOPS_ST_RUN || !count_start_bit || one_stop)
         out_reg <= output_initial_level_bit;
      else if (run_tick && cnt_reg == end_point && !m_per)
         out_reg <= output_initial_level_bit;
      else if (m_wait && !m_per)
         out_reg <= ~output_initial_level_bit;
   end

   // Registered outputs; the pin is dedicated to this mode only
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwm_output_pin      <= 1'b0;
         pwm_output_pin_oe   <= 1'b0;
         timer_counter_value <= TOPS_CNT_RST;
         compare_match_event <= 4'h0;
         overflow_event      <= 1'b0;
         counting            <= 1'b0;
      end
      else
      begin
         pwm_output_pin      <= out_reg;
         pwm_output_pin_oe   <= 1'b1;
         timer_counter_value <= cnt_reg;
         compare_match_event <= {m_buf, m_wait, m_end, m_per};
         overflow_event      <= ovf;
         counting            <= (state_reg == TOPS_ST_RUN);
      end
   end

   // Start bit alone starts counting when the trigger is not used
   property p_start_untrig;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == TOPS_ST_IDLE && count_start_bit && !trg_used && !done_reg) |=>
         state_reg == TOPS_ST_RUN;
   endproperty
   a_start_untrig: assert property (p_start_untrig) else $error("No start");

   // Armed state holds until a valid edge
   property p_arm_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == TOPS_ST_ARM && count_start_bit && !trg_edge) |=> state_reg == TOPS_ST_ARM;
   endproperty
   a_arm_hold: assert property (p_arm_hold) else $error("Started without trigger");

   // Stopping keeps the counter and returns to the initial level
   sequence s_stop;
      (state_reg != TOPS_ST_IDLE) && !count_start_bit;
   endsequence
   property p_stop;
      @(posedge ref_clk) disable iff (!rst_n)
      s_stop |=> (cnt_reg == $past(cnt_reg)) ##1
         (pwm_output_pin == $past(output_initial_level_bit, 2));
   endproperty
   a_stop: assert property (p_stop) else $error("Stop misbehaved");

   // One-shot period match ends the run
   property p_one_shot;
      @(posedge ref_clk) disable iff (!rst_n)
      one_stop |=> state_reg == ($past(trg_used) ? TOPS_ST_ARM : TOPS_ST_IDLE) &&
         out_reg == $past(output_initial_level_bit);
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("One-shot did not stop");

   // Clear-on-match zeroes the counter at one-shot stop
   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      (one_stop && clear_on_period_match_bit) |=> cnt_reg == TOPS_CNT_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("Counter not cleared");

   // Continuous period wraps at period register
   property p_period;
      @(posedge ref_clk) disable iff (!rst_n)
      (m_per && !one_shot_select_bit) |=> cnt_reg == 16'h0000;
   endproperty
   a_period: assert property (p_period) else $error("Period wrap wrong");

   // Wait match drives the active level
   property p_wait;
      @(posedge ref_clk) disable iff (!rst_n)
      (m_wait && !m_per && cnt_reg != end_point && count_start_bit) |=>
         out_reg == !$past(output_initial_level_bit);
   endproperty
   a_wait: assert property (p_wait) else $error("Wait match ignored");

   // Overflow event follows counter max
   property p_ovf;
      @(posedge ref_clk) disable iff (!rst_n)
      ovf |=> overflow_event;
   endproperty
   a_ovf: assert property (p_ovf) else $error("Overflow missed");
endmodule : tops_timer
`default_nettype wire

// *** tops_far_side.sv ***
// Purpose: Far side of the timer: trigger source, count clocks, pin pull-up
// Assumes: The output wire has a pull-up while the timer releases it
// Notes:   Oscillator runs free; external clock stands still unless enabled
`default_nettype none
module tops_far_side
(
   input  wire logic ext_en,            // Run the external count clock
   input  wire logic pwm_output_pin,    // Timer pin level
   input  wire logic pwm_output_pin_oe, // Timer drives the pin
   output logic      trigger_input_pin, // Trigger source level
   output logic      external_count_clock_pin,
   output logic      internal_osc_fast_clock,
   output wire logic pin_level          // Resolved wire level
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pull-up wins once the timer lets go, so a stale level never shows
   assign pin_level = pwm_output_pin_oe ? pwm_output_pin : 1'b1;
   // Quiet levels at time zero
   initial
   begin
      trigger_input_pin        = 1'b0;
      external_count_clock_pin = 1'b0;
      internal_osc_fast_clock  = 1'b0;
   end
   // Fast oscillator, 25 ns period, unrelated to ref_clk
   always #12.5 internal_osc_fast_clock = ~internal_osc_fast_clock;
   // External clock, 40 ns period, parked low while disabled
   initial
   begin
      #1;
      forever
      begin
         #20;
         external_count_clock_pin = ext_en & ~external_count_clock_pin;
      end
   end
   // Trigger level change, kept off the ref_clk edge
   task automatic drive(input logic v);
      #1;
      trigger_input_pin = v;
   endtask : drive
endmodule : tops_far_side
`default_nettype wire

// *** test_triggered_one_shot_pwm.sv ***
// Purpose: Self-checking bench for the triggered one-shot pulse timer
// Assumes: Far-side model gives trigger, count clocks and pull-up
// Notes:   Widths are counted in ref_clk cycles on the resolved wire
`default_nettype none
`define CHK(got, exp, msg) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("wrong value at %0t: %s", $time, msg); \
      end \
   end
module test_triggered_one_shot_pwm
   import tops_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk = 1'b0;  // 250 MHz
   logic        rst_n   = 1'b0;  // Held low at start
   logic        start, eh, el, os, init, clr, bfe, tsel, ext_en;
   logic [2:0]  src;             // Count source code
   logic [15:0] m, n, p, b, cnt; // Compare values and count
   logic [3:0]  evt, seen;       // Compare events and their union
   logic        pin, oe, ovf, run, trg, eclk, osc, lvl;
   int          n_mismatch  = 0;
   int          check_count = 0;
   always #2 ref_clk = ~ref_clk;
   // Union of compare events since the last clear
   always @(posedge ref_clk) seen <= seen | evt;
   tops_timer u_dut
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .count_start_bit(start),
      .trigger_edge_sel_hi(eh), .trigger_edge_sel_lo(el), .one_shot_select_bit(os),
      .output_initial_level_bit(init), .clear_on_period_match_bit(clr),
      .buffer_enable_fourth(bfe), .first_pin_trigger_sel(tsel), .count_source_sel(src),
      .period_compare_reg(m), .pulse_end_compare_reg(n), .wait_compare_reg(p),
      .buffer_compare_reg(b), .trigger_input_pin(trg), .external_count_clock_pin(eclk),
      .internal_osc_fast_clock(osc), .pwm_output_pin(pin), .pwm_output_pin_oe(oe),
      .timer_counter_value(cnt), .compare_match_event(evt), .overflow_event(ovf),
      .counting(run)
   );
   tops_far_side u_far
   (
      .ext_en(ext_en), .pwm_output_pin(pin), .pwm_output_pin_oe(oe),
      .trigger_input_pin(trg), .external_count_clock_pin(eclk),
      .internal_osc_fast_clock(osc), .pin_level(lvl)
   );
   // Verdict and end of run
   task automatic end_sim();
      if (n_mismatch == 0 && check_count > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   // Bounded wait for a wire level; k counts the cycles spent
   task automatic wait_lvl(input logic v, input int lim, output int k);
      k = 0;
      // Sample on the falling edge, where the pin has settled
      while (lvl !== v && k < lim)
      begin
         @(negedge ref_clk);
         k++;
      end
      `CHK(lvl, v, "level wait timed out")
      if (lvl !== v)
      begin
         end_sim();
      end
   endtask : wait_lvl
   // Delay to active, active width and full period of one pulse
   task automatic measure(output int dly, output int hi, output int per);
      int k;
      wait_lvl(~init, 3000, dly);
      `CHK(dly < 3000, 1'b1, "pin never went active")
      if (dly >= 3000)
      begin
         end_sim();
      end
      wait_lvl(init, 3000, hi);
      if (!os)
      begin
         wait_lvl(~init, 400, k);
      end
      else
      begin
         // A one-shot never goes active again; let it reach its period match
         k = 0;
         repeat (12) @(negedge ref_clk);
      end
      per = hi + k;
   endtask : measure
   // Control changes only with the counter stopped
   task automatic cfg(input logic [2:0] s, input logic [1:0] t, input logic o, i, c,
                      input logic [15:0] mm, nn, pp);
      start <= 1'b0;
      repeat (4) @(posedge ref_clk);
      {src, eh, el, os, init, clr} <= {s, t, o, i, c};
      {m, n, p} <= {mm, nn, pp};
      repeat (4) @(posedge ref_clk);
   endtask : cfg
   task automatic go();
      start <= 1'b1;
      @(posedge ref_clk);
   endtask : go
   // Clearing start parks the pin and freezes the count
   task automatic stop_chk();
      logic [15:0] held;
      start <= 1'b0;
      repeat (4) @(posedge ref_clk);
      held = cnt;
      repeat (3) @(posedge ref_clk);
      `CHK(run, 1'b0, "still counting")
      `CHK(lvl, init, "pin not at initial level")
      `CHK(cnt, held, "count moved while stopped")
   endtask : stop_chk
   // Every count source, both initial levels, continuous running
   task automatic s_sources();
      int d[6] = '{1, 2, 4, 8, 32, 10};
      int dly, hi, per;
      for (int i = 0; i < 6; i++)
      begin
         ext_en <= (i == 5);
         cfg((i == 5) ? 3'h6 : 3'(i), 2'b00, 1'b0, 1'(i % 2), 1'b0,
             16'h0003, 16'h0002, 16'h0000);
         seen = 4'h0;
         go();
         measure(dly, hi, per);
         `CHK(hi, 2 * d[i], "active width")
         `CHK(per, 4 * d[i], "period")
         `CHK(oe, 1'b1, "pin not driven")
         `CHK(seen, 4'hf, "compare events")
         stop_chk();
      end
      // Fast oscillator is unrelated to ref_clk, so allow one cycle of jitter
      cfg(3'h5, 2'b00, 1'b0, 1'b0, 1'b0, 16'h0003, 16'h0002, 16'h0000);
      go();
      measure(dly, hi, per);
      `CHK(hi >= 12 && hi <= 13, 1'b1, "oscillator width")
      `CHK(per >= 24 && per <= 26, 1'b1, "oscillator period")
      stop_chk();
      ext_en <= 1'b0;
   endtask : s_sources
   // End point taken from the fourth register
   task automatic s_buffer();
      int dly, hi, per;
      cfg(3'h0, 2'b00, 1'b0, 1'b0, 1'b0, 16'h0005, 16'h0001, 16'h0000);
      {bfe, b} <= {1'b1, 16'h0003};
      go();
      measure(dly, hi, per);
      `CHK(hi, 3, "buffered width")
      stop_chk();
      {bfe, b} <= {1'b0, 16'h0001};
   endtask : s_buffer
   // One-shot stop, with and without clearing; two wait values
   task automatic s_oneshot();
      int dly[2];
      int hi, per;
      for (int i = 0; i < 2; i++)
      begin
         // Reset mid-run so each shot counts from zero, not the retained count
         {rst_n, start} <= 2'b00;
         repeat (2) @(posedge ref_clk);
         `CHK({oe, cnt}, 17'h00000, "outputs not cleared in reset")
         rst_n <= 1'b1;
         cfg(3'h0, 2'b00, 1'b1, 1'b0, 1'(i), 16'(2 * i + 7), 16'(2 * i + 4), 16'(2 * i + 2));
         go();
         measure(dly[i], hi, per);
         `CHK(hi, 2, "one-shot width")
         `CHK(run, 1'b0, "one-shot kept counting")
         `CHK(lvl, 1'b0, "pin not back at initial")
         `CHK(cnt, (i == 1) ? 16'h0000 : 16'(2 * i + 7), "count after stop")
      end
      `CHK(dly[1] - dly[0], 2, "wait time")
   endtask : s_oneshot
   // Trigger refused from the port pin, then each edge setting
   task automatic s_trig();
      int dly, hi, per;
      tsel <= 1'b0;
      cfg(3'h0, 2'b01, 1'b1, 1'b0, 1'b0, 16'h0027, 16'h0022, 16'h0020);
      go();
      u_far.drive(1'b1);
      repeat (10) @(posedge ref_clk);
      `CHK(run, 1'b0, "trigger taken from port pin")
      for (int e = 1; e < 4; e++)
      begin
         cfg(3'h0, 2'(e), 1'b1, 1'b0, 1'b1, 16'h0027, 16'h0022, 16'h0020);
         tsel <= 1'b1;
         u_far.drive(e == 1);
         repeat (6) @(posedge ref_clk);
         go();
         u_far.drive(e != 1);
         repeat (10) @(posedge ref_clk);
         `CHK(run, 1'(e == 3), "start on wrong edge")
         u_far.drive(e == 1);
         measure(dly, hi, per);
         `CHK(hi, 2, "triggered width")
         `CHK(run, 1'b0, "triggered shot kept counting")
         `CHK(cnt, 16'h0000, "count not cleared at shot end")
      end
   endtask : s_trig
   // Free run through the top of the count
   task automatic s_ovf();
      int k;
      cfg(3'h0, 2'b00, 1'b0, 1'b0, 1'b0, 16'hffff, 16'h0002, 16'h0000);
      go();
      k = 0;
      while (ovf !== 1'b1 && k < 70000)
      begin
         @(negedge ref_clk);
         k++;
      end
      `CHK(k > 65530 && k < 65545, 1'b1, "overflow timing")
      stop_chk();
   endtask : s_ovf
   // Main sequence
   initial
   begin
      {start, eh, el, os, init, clr, bfe, tsel, ext_en} <= 9'h000;
      {src, m, n, p, b} <= {3'h0, 16'h0003, 16'h0002, 16'h0000, 16'h0001};
      seen = 4'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      s_sources();
      s_buffer();
      s_oneshot();
      s_trig();
      s_ovf();
      end_sim();
   end
endmodule : test_triggered_one_shot_pwm
`default_nettype wire
